// *** include/midt_pkg.sv ***
// What this block does
// - Source registers mirror each sub-block's interrupt
// - Reading source registers clears nothing
// - Payload loop feeds elastic store to transmitter
// - Payload loop forces backplane receive PCM high
// - Line loop routes recovered pulses to attenuator
// - Digital loop routes attenuator pulses to recovery
// - Metallic loop routes sliced transmit pulses back
// - Mimic framing copies framing bit into bit 1
// - Transmit disable forces transmitter output low
// - Diagnostic bits clear on device reset
// - Hardware reset clears test bits except factory
// - Factory test bit ORed, cleared by chip select
// - Driver control gives bus enable to chip select
// - Board test holds sub-blocks in test mode
// - Pin tristate floats all pins except data bus
// - Bus tristate floats data bus, blocks reads, unless driver control is set
package midt_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int IRQ_PRI_W = 7;
  localparam int IRQ_SEC_W = 6;

  localparam logic [ADDR_W-1:0] IRQ_SOURCE_PRIMARY_OFS   = 8'h08;
  localparam logic [ADDR_W-1:0] IRQ_SOURCE_SECONDARY_OFS = 8'h09;
  localparam logic [ADDR_W-1:0] DIAGNOSTIC_CONTROL_OFS   = 8'h0A;
  localparam logic [ADDR_W-1:0] TEST_CONTROL_OFS         = 8'h0B;

  // Primary source bit positions
  localparam int ALARM_IRQ_BIT       = 0;
  localparam int RX_BITCODE_IRQ_BIT  = 1;
  localparam int RX_DATALINK_IRQ_BIT = 2;
  localparam int ELASTIC_STORE_BIT   = 3;
  localparam int PULSE_DENSITY_BIT   = 4;
  localparam int FRAMER_IRQ_BIT      = 5;
  localparam int INBAND_CODE_BIT     = 6;

  // Secondary source bit positions
  localparam int CLOCK_DATA_REC_BIT  = 0;
  localparam int TX_DATALINK_BIT     = 1;
  localparam int TX_PULSE_GEN_BIT    = 2;
  localparam int RX_SLC_IRQ_BIT      = 3;
  localparam int TX_DENSITY_BIT      = 4;
  localparam int JITTER_ATTEN_BIT    = 5;

  // Diagnostic control bit positions
  localparam int TRANSMIT_DISABLE_BIT = 0;
  localparam int MIMIC_FRAMING_BIT    = 1;
  localparam int DIGITAL_LOOP_BIT     = 2;
  localparam int METALLIC_LOOP_BIT    = 3;
  localparam int LINE_LOOP_BIT        = 4;
  localparam int PAYLOAD_LOOP_BIT     = 5;

  // Test control bit positions
  localparam int PINS_TRISTATE_BIT  = 0;
  localparam int BUS_TRISTATE_BIT   = 1;
  localparam int BOARD_TEST_BIT     = 2;
  localparam int BUS_DRIVER_CS_BIT  = 3;
  localparam int FACTORY_TEST_BIT   = 4;

  localparam logic [5:0] DIAGNOSTIC_CONTROL_RST = 6'h00;
  localparam logic [3:0] TEST_CONTROL_RST       = 4'h0;
  localparam logic       FACTORY_TEST_RST       = 1'h0;

  // Readable bits of the test register: board test and pin tristate
  localparam logic [DATA_W-1:0] TEST_CONTROL_READ_MASK = 8'h05;

endpackage : midt_pkg

// *** verilog/midt_tx_shaper.sv ***
`timescale 1ns/1ps
module midt_tx_shaper
  import midt_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic tx_bit_in,
  input  wire logic framing_slot,
  input  wire logic bit1_slot,
  input  wire logic mimic_framing_en,
  input  wire logic transmit_disable,
  output logic      tx_bit_out
);

  logic framing_bit_q;
  logic framing_bit_d;
  logic shaped_bit;
  logic tx_bit_out_q;
  logic tx_bit_out_d;

  // Remember the framing bit of the current frame
  assign framing_bit_d = framing_slot ? tx_bit_in : framing_bit_q;

  // Bit 1 repeats the framing bit; a same-cycle framing slot is not possible
  assign shaped_bit = (mimic_framing_en && bit1_slot) ? framing_bit_q : tx_bit_in;

  assign tx_bit_out_d = transmit_disable ? 1'b0 : shaped_bit;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      framing_bit_q <= 1'b0;
      tx_bit_out_q  <= 1'b0;
    end
    else
    begin
      framing_bit_q <= framing_bit_d;
      tx_bit_out_q  <= tx_bit_out_d;
    end
  end

  assign tx_bit_out = tx_bit_out_q;

endmodule : midt_tx_shaper

// *** verilog/midt_regs.sv ***
`timescale 1ns/1ps
module midt_regs
  import midt_pkg::*;
(
  input  wire logic                         sys_clk,
  input  wire logic                         rst_n,
  input  wire logic                         soft_reset,
  // Microprocessor port
  input  wire logic                         chip_select_n,
  input  wire logic                         rd_n,
  input  wire logic                         wr_n,
  input  wire logic [midt_pkg::ADDR_W-1:0]  addr,
  input  wire logic [midt_pkg::DATA_W-1:0]  data_in,
  output logic      [midt_pkg::DATA_W-1:0]  data_out,
  output logic                              data_oe,
  output logic                              irq_out_n,
  // Sub-block interrupt requests
  input  wire logic                         inband_code_irq,
  input  wire logic                         framer_irq,
  input  wire logic                         pulse_density_irq,
  input  wire logic                         elastic_store_irq,
  input  wire logic                         rx_datalink_irq,
  input  wire logic                         rx_bitcode_irq,
  input  wire logic                         alarm_irq,
  input  wire logic                         jitter_attenuator_irq,
  input  wire logic                         tx_density_irq,
  input  wire logic                         rx_slc_irq,
  input  wire logic                         tx_pulse_generator_irq,
  input  wire logic                         tx_datalink_irq,
  input  wire logic                         clock_data_recovery_irq,
  // Payload path
  input  wire logic                         elastic_store_data,
  input  wire logic                         backplane_tx_data,
  output logic                              basic_transmitter_data,
  output logic                              backplane_rx_pcm,
  // Line path
  input  wire logic                         cdr_pos_out,
  input  wire logic                         cdr_neg_out,
  input  wire logic                         tx_line_pos,
  input  wire logic                         tx_line_neg,
  output logic                              ja_pos_in,
  output logic                              ja_neg_in,
  // Receive recovery inputs
  input  wire logic                         ja_rz_pos,
  input  wire logic                         ja_rz_neg,
  input  wire logic                         sliced_tx_pos,
  input  wire logic                         analog_tx_neg_sliced,
  input  wire logic                         rx_line_pos,
  input  wire logic                         rx_line_neg,
  output logic                              cdr_pos_in,
  output logic                              cdr_neg_in,
  // Basic transmitter output shaping
  input  wire logic                         tx_bit_in,
  input  wire logic                         framing_slot,
  input  wire logic                         bit1_slot,
  output logic                              tx_bit_out,
  // Test controls
  output logic                              test_access_en,
  output logic                              board_test_en,
  output logic                              pins_output_en,
  output logic                              payload_loop_en,
  output logic                              line_loop_en,
  output logic                              metallic_loop_en,
  output logic                              digital_loop_en
);

  import midt_pkg::*;

  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    addr_is = (a == ofs);
  endfunction : addr_is

  logic [IRQ_PRI_W-1:0] irq_pri_in;
  logic [IRQ_SEC_W-1:0] irq_sec_in;
  logic [IRQ_PRI_W-1:0] irq_pri_q;
  logic [IRQ_SEC_W-1:0] irq_sec_q;
  logic                 irq_out_n_q;
  logic                 irq_out_n_d;

  logic [5:0]           diag_q;
  logic [5:0]           diag_d;
  logic [3:0]           test_q;
  logic [3:0]           test_d;
  logic                 factory_q;
  logic                 factory_d;

  logic                 wr_active;
  logic                 wr_active_q;
  logic                 wr_start;
  logic                 rd_active;
  logic                 hit_pri;
  logic                 hit_sec;
  logic                 hit_diag;
  logic                 hit_test;
  logic                 hit_any;
  logic [DATA_W-1:0]    rd_mux;
  logic [DATA_W-1:0]    test_read;

  logic [DATA_W-1:0]    data_out_q;
  logic                 data_oe_q;
  logic                 data_oe_d;

  logic                 bt_data_q;
  logic                 bt_data_d;
  logic                 rx_pcm_q;
  logic                 rx_pcm_d;
  logic                 ja_pos_q;
  logic                 ja_neg_q;
  logic                 ja_pos_d;
  logic                 ja_neg_d;
  logic                 cdr_pos_q;
  logic                 cdr_neg_q;
  logic                 cdr_pos_d;
  logic                 cdr_neg_d;
  logic                 test_access_q;
  logic                 board_test_q;
  logic                 board_test_d;
  logic                 pins_oe_q;

  // Interrupt request capture
  assign irq_pri_in[ALARM_IRQ_BIT]       = alarm_irq;
  assign irq_pri_in[RX_BITCODE_IRQ_BIT]  = rx_bitcode_irq;
  assign irq_pri_in[RX_DATALINK_IRQ_BIT] = rx_datalink_irq;
  assign irq_pri_in[ELASTIC_STORE_BIT]   = elastic_store_irq;
  assign irq_pri_in[PULSE_DENSITY_BIT]   = pulse_density_irq;
  assign irq_pri_in[FRAMER_IRQ_BIT]      = framer_irq;
  assign irq_pri_in[INBAND_CODE_BIT]     = inband_code_irq;

  assign irq_sec_in[CLOCK_DATA_REC_BIT]  = clock_data_recovery_irq;
  assign irq_sec_in[TX_DATALINK_BIT]     = tx_datalink_irq;
  assign irq_sec_in[TX_PULSE_GEN_BIT]    = tx_pulse_generator_irq;
  assign irq_sec_in[RX_SLC_IRQ_BIT]      = rx_slc_irq;
  assign irq_sec_in[TX_DENSITY_BIT]      = tx_density_irq;
  assign irq_sec_in[JITTER_ATTEN_BIT]    = jitter_attenuator_irq;

  // Source bits follow the sub-block level; a read never alters them
  genvar gi;
  generate
    for (gi = 0; gi < IRQ_PRI_W; gi++)
    begin : g_pri
      always_ff @(posedge sys_clk)
      begin
        if (!rst_n)
          irq_pri_q[gi] <= 1'b0;
        else
          irq_pri_q[gi] <= irq_pri_in[gi];
      end
    end
    for (gi = 0; gi < IRQ_SEC_W; gi++)
    begin : g_sec
      always_ff @(posedge sys_clk)
      begin
        if (!rst_n)
          irq_sec_q[gi] <= 1'b0;
        else
          irq_sec_q[gi] <= irq_sec_in[gi];
      end
    end
  endgenerate

  assign irq_out_n_d = ~(|irq_pri_in | |irq_sec_in);

  // Port decode
  assign hit_pri   = addr_is(addr, IRQ_SOURCE_PRIMARY_OFS);
  assign hit_sec   = addr_is(addr, IRQ_SOURCE_SECONDARY_OFS);
  assign hit_diag  = addr_is(addr, DIAGNOSTIC_CONTROL_OFS);
  assign hit_test  = addr_is(addr, TEST_CONTROL_OFS);
  assign hit_any   = hit_pri | hit_sec | hit_diag | hit_test;
  assign wr_active = ~chip_select_n & ~wr_n;
  assign wr_start  = wr_active & ~wr_active_q;
  assign rd_active = ~chip_select_n & ~rd_n & wr_n;

  // Write-only test bits read back as zero
  assign test_read = {4'h0, test_q} & TEST_CONTROL_READ_MASK;

  assign rd_mux = hit_pri  ? {1'b0, irq_pri_q} :
                  hit_sec  ? {2'b00, irq_sec_q} :
                  hit_diag ? {2'b00, diag_q} :
                  hit_test ? test_read :
                             8'h00;

  // Diagnostic register: hardware or software reset clears it
  assign diag_d = (wr_start && hit_diag) ? data_in[5:0] : diag_q;

  // Test register survives software reset
  assign test_d = (wr_start && hit_test) ? data_in[3:0] : test_q;

  // Factory test: chip select high or a write of zero clears it; reset leaves it
  assign factory_d = chip_select_n ? 1'b0 :
                     (wr_start && hit_test) ? data_in[FACTORY_TEST_BIT] :
                     factory_q;

  // Bus drivers: chip select owns them under driver control
  assign data_oe_d = test_q[BUS_DRIVER_CS_BIT] ? chip_select_n :
                     (rd_active & hit_any & ~test_q[BUS_TRISTATE_BIT]);

  assign board_test_d = test_q[BOARD_TEST_BIT] | factory_q;

  // Payload loop datapath
  assign bt_data_d = diag_q[PAYLOAD_LOOP_BIT] ? elastic_store_data :
                     backplane_tx_data;
  assign rx_pcm_d  = diag_q[PAYLOAD_LOOP_BIT] ? 1'b1 : elastic_store_data;

  // Line loop datapath
  assign ja_pos_d = diag_q[LINE_LOOP_BIT] ? cdr_pos_out : tx_line_pos;
  assign ja_neg_d = diag_q[LINE_LOOP_BIT] ? cdr_neg_out : tx_line_neg;

  // Recovery inputs: digital loop takes precedence over metallic
  assign cdr_pos_d = diag_q[DIGITAL_LOOP_BIT]  ? ja_rz_pos :
                     diag_q[METALLIC_LOOP_BIT] ? sliced_tx_pos :
                                                 rx_line_pos;
  assign cdr_neg_d = diag_q[DIGITAL_LOOP_BIT]  ? ja_rz_neg :
                     diag_q[METALLIC_LOOP_BIT] ? analog_tx_neg_sliced :
                                                 rx_line_neg;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || soft_reset)
      diag_q <= DIAGNOSTIC_CONTROL_RST;
    else
      diag_q <= diag_d;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      test_q <= TEST_CONTROL_RST;
    else
      test_q <= test_d;
  end

  always_ff @(posedge sys_clk)
  begin
    factory_q <= factory_d;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wr_active_q <= 1'b0;
      data_out_q  <= 8'h00;
      data_oe_q   <= 1'b0;
      irq_out_n_q <= 1'b1;
    end
    else
    begin
      wr_active_q <= wr_active;
      data_out_q  <= rd_mux;
      data_oe_q   <= data_oe_d;
      irq_out_n_q <= irq_out_n_d;
    end
  end

  // Payload loop outputs
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      bt_data_q <= 1'b0;
      rx_pcm_q  <= 1'b1;
    end
    else
    begin
      bt_data_q <= bt_data_d;
      rx_pcm_q  <= rx_pcm_d;
    end
  end

  // Jitter attenuator inputs
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ja_pos_q <= 1'b0;
      ja_neg_q <= 1'b0;
    end
    else
    begin
      ja_pos_q <= ja_pos_d;
      ja_neg_q <= ja_neg_d;
    end
  end

  // Clock recovery inputs
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cdr_pos_q <= 1'b0;
      cdr_neg_q <= 1'b0;
    end
    else
    begin
      cdr_pos_q <= cdr_pos_d;
      cdr_neg_q <= cdr_neg_d;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      test_access_q <= FACTORY_TEST_RST;
      board_test_q  <= 1'b0;
      pins_oe_q     <= 1'b1;
    end
    else
    begin
      test_access_q <= factory_q;
      board_test_q  <= board_test_d;
      pins_oe_q     <= ~test_q[PINS_TRISTATE_BIT];
    end
  end

  midt_tx_shaper u_tx_shaper (
    .sys_clk          (sys_clk),
    .rst_n            (rst_n),
    .tx_bit_in        (tx_bit_in),
    .framing_slot     (framing_slot),
    .bit1_slot        (bit1_slot),
    .mimic_framing_en (diag_q[MIMIC_FRAMING_BIT]),
    .transmit_disable (diag_q[TRANSMIT_DISABLE_BIT]),
    .tx_bit_out       (tx_bit_out)
  );

  assign data_out               = data_out_q;
  assign data_oe                = data_oe_q;
  assign irq_out_n              = irq_out_n_q;
  assign basic_transmitter_data = bt_data_q;
  assign backplane_rx_pcm       = rx_pcm_q;
  assign ja_pos_in              = ja_pos_q;
  assign ja_neg_in              = ja_neg_q;
  assign cdr_pos_in             = cdr_pos_q;
  assign cdr_neg_in             = cdr_neg_q;
  assign test_access_en         = test_access_q;
  assign board_test_en          = board_test_q;
  assign pins_output_en         = pins_oe_q;
  assign payload_loop_en        = diag_q[PAYLOAD_LOOP_BIT];
  assign line_loop_en           = diag_q[LINE_LOOP_BIT];
  assign metallic_loop_en       = diag_q[METALLIC_LOOP_BIT];
  assign digital_loop_en        = diag_q[DIGITAL_LOOP_BIT];

endmodule : midt_regs

// *** sim/midt_regs_chk.sv ***
`timescale 1ns/1ps
module midt_regs_chk
  import midt_pkg::*;
(
  input wire logic                         sys_clk,
  input wire logic                         rst_n,
  input wire logic                         chip_select_n,
  input wire logic                         rd_n,
  input wire logic                         wr_n,
  input wire logic [midt_pkg::ADDR_W-1:0]  addr,
  input wire logic                         data_oe,
  input wire logic                         irq_out_n,
  input wire logic                         elastic_store_data,
  input wire logic                         backplane_tx_data,
  input wire logic                         basic_transmitter_data,
  input wire logic                         backplane_rx_pcm,
  input wire logic                         payload_loop_en,
  input wire logic                         cdr_pos_out,
  input wire logic                         ja_pos_in,
  input wire logic                         line_loop_en,
  input wire logic                         ja_rz_pos,
  input wire logic                         sliced_tx_pos,
  input wire logic                         cdr_pos_in,
  input wire logic                         digital_loop_en,
  input wire logic                         metallic_loop_en,
  input wire logic                         test_access_en
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // Read cycle aimed outside the register map
  wire rd_unmapped = !chip_select_n && !rd_n && wr_n && (addr < 8'h08 || addr > 8'h0B);

  a_reset_clear: assert property (
    $rose(rst_n) |-> irq_out_n && !data_oe && backplane_rx_pcm && !payload_loop_en
      && !line_loop_en && !digital_loop_en && !metallic_loop_en)
    else $error("outputs not at reset values after reset release");
  a_payload_pcm: assert property (
    payload_loop_en |=> backplane_rx_pcm)
    else $error("receive PCM not forced high in payload loop");
  a_payload_data: assert property (
    payload_loop_en |=> basic_transmitter_data == $past(elastic_store_data))
    else $error("transmitter not fed from elastic store in payload loop");
  a_normal_path: assert property (
    !payload_loop_en |=> basic_transmitter_data == $past(backplane_tx_data)
      && backplane_rx_pcm == $past(elastic_store_data))
    else $error("normal payload path broken");
  a_line_route: assert property (
    line_loop_en |=> ja_pos_in == $past(cdr_pos_out))
    else $error("attenuator input not from recovered pulses in line loop");
  a_digital_route: assert property (
    digital_loop_en |=> cdr_pos_in == $past(ja_rz_pos))
    else $error("recovery input not from attenuator in digital loop");
  a_metal_route: assert property (
    metallic_loop_en && !digital_loop_en |=> cdr_pos_in == $past(sliced_tx_pos))
    else $error("recovery input not from sliced transmit in metallic loop");
  a_unmapped_quiet: assert property (
    rd_unmapped |=> !data_oe)
    else $error("data bus driven for unmapped read");
  a_factory_clear: assert property (
    chip_select_n [*3] |=> !test_access_en)
    else $error("factory test stays set with chip select high");

  c_payload: cover property (payload_loop_en);
  c_metal: cover property (metallic_loop_en && !digital_loop_en);
  c_factory: cover property (test_access_en);
  c_unmapped: cover property (rd_unmapped);
endmodule : midt_regs_chk

bind midt_regs midt_regs_chk u_chk (.*);

// *** sim/midt_host.sv ***
`timescale 1ns/1ps
module midt_host
  import midt_pkg::*;
(
  input  wire logic                         sys_clk,
  output logic                              chip_select_n,
  output logic                              rd_n,
  output logic                              wr_n,
  output logic      [midt_pkg::ADDR_W-1:0]  addr,
  output logic      [midt_pkg::DATA_W-1:0]  data_in,
  input  wire logic [midt_pkg::DATA_W-1:0]  data_out,
  input  wire logic                         data_oe
);
  initial
  begin
    chip_select_n = 1'h1;
    rd_n = 1'h1;
    wr_n = 1'h1;
    addr = 8'h00;
    data_in = 8'h00;
  end

  // One strobe per write; keep leaves chip select low afterwards
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic keep);
    @(negedge sys_clk);
    addr = a;
    data_in = d;
    chip_select_n = 1'h0;
    wr_n = 1'h0;
    @(negedge sys_clk);
    wr_n = 1'h1;
    data_in = ~d;
    if (!keep)
      chip_select_n = 1'h1;
  endtask : wr_reg

  task automatic idle();
    @(negedge sys_clk);
    chip_select_n = 1'h1;
    addr = ~addr;
  endtask : idle

  // Reads expect no indication to be cleared
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic oe);
    @(negedge sys_clk);
    addr = a;
    chip_select_n = 1'h0;
    rd_n = 1'h0;
    @(negedge sys_clk);
    d = data_out;
    oe = data_oe;
    rd_n = 1'h1;
    chip_select_n = 1'h1;
    addr = ~a;
  endtask : rd_reg
endmodule : midt_host

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import midt_pkg::*;
  logic                sys_clk, rst_n, soft_reset;
  logic                chip_select_n, rd_n, wr_n, data_oe, irq_out_n;
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   data_in, data_out, rd_d;
  logic [12:0]         irq_v;
  logic                elastic_store_data, backplane_tx_data, rd_oe;
  logic                basic_transmitter_data, backplane_rx_pcm;
  logic [1:0]          cdr_o, txl, jaz, slc, rxl, ja_in, cdr_in;
  logic                tx_bit_in, framing_slot, bit1_slot, tx_bit_out;
  logic                test_access_en, board_test_en, pins_output_en;
  logic                payload_loop_en, line_loop_en, metallic_loop_en, digital_loop_en;
  int                  n_mismatch, comparisons;

  midt_host u_host (.*);
  midt_regs u_dut (
    .*,
    .alarm_irq(irq_v[ALARM_IRQ_BIT]), .rx_bitcode_irq(irq_v[RX_BITCODE_IRQ_BIT]),
    .rx_datalink_irq(irq_v[RX_DATALINK_IRQ_BIT]), .elastic_store_irq(irq_v[ELASTIC_STORE_BIT]),
    .pulse_density_irq(irq_v[PULSE_DENSITY_BIT]), .framer_irq(irq_v[FRAMER_IRQ_BIT]),
    .inband_code_irq(irq_v[INBAND_CODE_BIT]),
    .clock_data_recovery_irq(irq_v[7+CLOCK_DATA_REC_BIT]),
    .tx_datalink_irq(irq_v[7+TX_DATALINK_BIT]), .tx_pulse_generator_irq(irq_v[7+TX_PULSE_GEN_BIT]),
    .rx_slc_irq(irq_v[7+RX_SLC_IRQ_BIT]), .tx_density_irq(irq_v[7+TX_DENSITY_BIT]),
    .jitter_attenuator_irq(irq_v[7+JITTER_ATTEN_BIT]),
    .cdr_pos_out(cdr_o[1]), .cdr_neg_out(cdr_o[0]), .tx_line_pos(txl[1]), .tx_line_neg(txl[0]),
    .ja_pos_in(ja_in[1]), .ja_neg_in(ja_in[0]), .ja_rz_pos(jaz[1]), .ja_rz_neg(jaz[0]),
    .sliced_tx_pos(slc[1]), .analog_tx_neg_sliced(slc[0]), .rx_line_pos(rxl[1]),
    .rx_line_neg(rxl[0]), .cdr_pos_in(cdr_in[1]), .cdr_neg_in(cdr_in[0])
  );

  always #2.5 sys_clk = ~sys_clk;

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    u_host.rd_reg(a, rd_d, rd_oe);
    chk("read data", rd_d, exp);
    chk("read drive", rd_oe, 1'h1);
  endtask : rdchk

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task automatic do_reset();
    @(negedge sys_clk);
    rst_n = 1'h0;
    repeat (4) @(negedge sys_clk);
    rst_n = 1'h1;
  endtask : do_reset

  task automatic shp(input logic f, input logic b, input logic t);
    @(negedge sys_clk);
    framing_slot = f;
    bit1_slot = b;
    tx_bit_in = t;
  endtask : shp

  task automatic t_irq();
    for (int i = 0; i < 14; i++)
    begin
      @(negedge sys_clk);
      irq_v = (i == 13) ? 13'h1FFF : 13'h0001 << i;
      repeat (2) @(negedge sys_clk);
      chk("irq_out_n", irq_out_n, 1'h0);
      rdchk(IRQ_SOURCE_PRIMARY_OFS, {1'h0, irq_v[6:0]});
      rdchk(IRQ_SOURCE_SECONDARY_OFS, {2'h0, irq_v[12:7]});
      rdchk(IRQ_SOURCE_PRIMARY_OFS, {1'h0, irq_v[6:0]});
    end
    irq_v = 13'h0000;
    repeat (2) @(negedge sys_clk);
    chk("irq_out_n", irq_out_n, 1'h1);
    u_host.wr_reg(IRQ_SOURCE_PRIMARY_OFS, 8'hFF, 1'h0);
    rdchk(IRQ_SOURCE_PRIMARY_OFS, 8'h00);
  endtask : t_irq

  task automatic t_payload();
    for (int m = 0; m < 2; m++)
    begin
      u_host.wr_reg(DIAGNOSTIC_CONTROL_OFS, m ? 8'h00 : 8'h20, 1'h0);
      chk("payload_loop_en", payload_loop_en, m ? 1'h0 : 1'h1);
      for (int k = 0; k < 4; k++)
      begin
        @(negedge sys_clk);
        elastic_store_data = k[0];
        backplane_tx_data = k[1];
        @(negedge sys_clk);
        chk("tx data", basic_transmitter_data, m ? k[1] : k[0]);
        chk("rx pcm", backplane_rx_pcm, m ? k[0] : 1'h1);
      end
    end
  endtask : t_payload

  task automatic t_routes();
    logic [7:0] mode [5] = '{8'h10, 8'h00, 8'h04, 8'h08, 8'h0C};
    foreach (mode[m])
    begin
      u_host.wr_reg(DIAGNOSTIC_CONTROL_OFS, mode[m], 1'h0);
      chk("loop en", {line_loop_en, metallic_loop_en, digital_loop_en},
          mode[m][4:2]);
      for (int p = 0; p < 4; p++)
      begin
        @(negedge sys_clk);
        cdr_o = p[1:0];
        txl = p[1:0] ^ 2'h1;
        jaz = p[1:0] ^ 2'h1;
        slc = p[1:0] ^ 2'h2;
        rxl = p[1:0] ^ 2'h3;
        @(negedge sys_clk);
        chk("ja in", ja_in, mode[m][LINE_LOOP_BIT] ? cdr_o : txl);
        chk("cdr in", cdr_in, mode[m][DIGITAL_LOOP_BIT] ? jaz :
            mode[m][METALLIC_LOOP_BIT] ? slc : rxl);
      end
    end
  endtask : t_routes

  task automatic t_shaper();
    u_host.wr_reg(DIAGNOSTIC_CONTROL_OFS, 8'h02, 1'h0);
    shp(1'h1, 1'h0, 1'h1);
    shp(1'h0, 1'h1, 1'h0);
    shp(1'h0, 1'h0, 1'h0);
    chk("mimic one", tx_bit_out, 1'h1);
    shp(1'h1, 1'h0, 1'h0);
    shp(1'h0, 1'h1, 1'h1);
    shp(1'h0, 1'h0, 1'h1);
    chk("mimic zero", tx_bit_out, 1'h0);
    u_host.wr_reg(DIAGNOSTIC_CONTROL_OFS, 8'h01, 1'h0);
    shp(1'h0, 1'h0, 1'h1);
    shp(1'h0, 1'h0, 1'h1);
    chk("disabled", tx_bit_out, 1'h0);
    u_host.wr_reg(DIAGNOSTIC_CONTROL_OFS, 8'h00, 1'h0);
    shp(1'h0, 1'h0, 1'h1);
    shp(1'h0, 1'h0, 1'h1);
    chk("enabled", tx_bit_out, 1'h1);
  endtask : t_shaper

  task automatic t_test_reg();
    u_host.wr_reg(TEST_CONTROL_OFS, 8'h05, 1'h0);
    @(negedge sys_clk);
    chk("pins_output_en", pins_output_en, 1'h0);
    chk("board_test_en", board_test_en, 1'h1);
    rdchk(TEST_CONTROL_OFS, 8'h05);
    u_host.wr_reg(DIAGNOSTIC_CONTROL_OFS, 8'hFF, 1'h0);
    rdchk(DIAGNOSTIC_CONTROL_OFS, 8'h3F);
    @(negedge sys_clk);
    soft_reset = 1'h1;
    @(negedge sys_clk);
    soft_reset = 1'h0;
    rdchk(DIAGNOSTIC_CONTROL_OFS, 8'h00);
    rdchk(TEST_CONTROL_OFS, 8'h05);
    do_reset();
    chk("pins_output_en", pins_output_en, 1'h1);
    rdchk(TEST_CONTROL_OFS, 8'h00);
  endtask : t_test_reg

  task automatic t_bus();
    u_host.wr_reg(TEST_CONTROL_OFS, 8'h02, 1'h0);
    u_host.rd_reg(IRQ_SOURCE_PRIMARY_OFS, rd_d, rd_oe);
    chk("tristated read", rd_oe, 1'h0);
    u_host.wr_reg(TEST_CONTROL_OFS, 8'h0A, 1'h0);
    repeat (2) @(negedge sys_clk);
    chk("drive with cs high", data_oe, 1'h1);
    u_host.rd_reg(IRQ_SOURCE_PRIMARY_OFS, rd_d, rd_oe);
    chk("drive with cs low", rd_oe, 1'h0);
    u_host.wr_reg(TEST_CONTROL_OFS, 8'h00, 1'h0);
    u_host.rd_reg(8'h0C, rd_d, rd_oe);
    chk("unmapped drive", rd_oe, 1'h0);
    u_host.rd_reg(8'h07, rd_d, rd_oe);
    chk("unmapped drive", rd_oe, 1'h0);
  endtask : t_bus

  task automatic t_factory();
    u_host.wr_reg(TEST_CONTROL_OFS, 8'h10, 1'h1);
    repeat (2) @(negedge sys_clk);
    chk("test_access_en", test_access_en, 1'h1);
    chk("board_test_en", board_test_en, 1'h1);
    u_host.idle();
    repeat (3) @(negedge sys_clk);
    chk("test_access_en", test_access_en, 1'h0);
    chk("board_test_en", board_test_en, 1'h0);
    rdchk(TEST_CONTROL_OFS, 8'h00);
  endtask : t_factory

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    complete_run();
  end

  initial
  begin
    sys_clk = 1'h0;
    rst_n = 1'h0;
    soft_reset = 1'h0;
    irq_v = 13'h0000;
    elastic_store_data = 1'h0;
    backplane_tx_data = 1'h0;
    {cdr_o, txl, jaz, slc, rxl} = 10'h000;
    {tx_bit_in, framing_slot, bit1_slot} = 3'h0;
    n_mismatch = 0;
    comparisons = 0;
    do_reset();
    chk("irq_out_n", irq_out_n, 1'h1);
    chk("pins_output_en", pins_output_en, 1'h1);
    rdchk(DIAGNOSTIC_CONTROL_OFS, 8'h00);
    rdchk(TEST_CONTROL_OFS, 8'h00);
    t_irq();
    t_payload();
    t_routes();
    t_shaper();
    t_test_reg();
    t_bus();
    t_factory();
    complete_run();
  end
endmodule : tb_top
